// ===== core/msarc_pkg.sv
package msarc_pkg;
  localparam int CLK_NS       = 50;
  localparam int START_NS     = 50;
  localparam int START_CYC    = (START_NS + CLK_NS - 1) / CLK_NS;
  localparam int SAMPLE_NS    = 180;
  localparam int SAMPLE_CYC   = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAJOR_NS     = 900;
  localparam int MAJOR_CYC    = MAJOR_NS / CLK_NS;
  localparam int STROBE_NS    = 700;
  localparam int STROBE_CYC   = STROBE_NS / CLK_NS;
  localparam int RRCLR_CYC    = SAMPLE_CYC + 1;
  localparam logic [5:0] REFRESH_COUNT = 6'h34;
  localparam logic [5:0] TIMEOUT_COUNT = 6'h03;
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] DATA_OFF   = 8'h08;
  localparam logic       CTRL_RST   = 1'b0;
  localparam int ST_REQ_BIT   = 0;
  localparam int ST_GNT_BIT   = 1;
  localparam int ST_TMO_BIT   = 2;
  localparam int ST_ECC_BIT   = 3;
  localparam int ST_OOR_BIT   = 4;
  localparam int ST_ROW_LSB   = 8;
  localparam int ST_CYC_LSB   = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACCESS, ST_REFRESH} msarc_state_t;

  typedef struct packed {
    logic        clk_pulse;
    logic        access_en;
    logic [0:15] addr;
    logic [0:3]  ext;
  } msarc_cpu_t;

  typedef struct packed {
    logic [8:0] left;
    logic [8:0] right;
    logic [4:0] chk_left;
    logic [4:0] chk_right;
  } msarc_sense_t;
endpackage

// ===== core/msarc_top.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module msarc_top (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // processor side
  input  wire msarc_pkg::msarc_cpu_t cpu_in,
  output logic                       refresh_req,
  output logic                       refresh_timeout,
  output logic                       out_of_range,
  output logic                       ecc_error,
  output logic      [17:0]           read_data,
  // storage array side
  input  wire msarc_pkg::msarc_sense_t sense_in,
  output logic      [4:0]            elem_row,
  output logic      [4:0]            elem_col,
  output logic      [3:0]            col_sel,
  output logic      [15:0]           mod_sel,
  output logic      [15:0]           board_addr_en,
  output logic      [63:0]           chip_en,
  output logic      [15:0]           left_byte_en,
  output logic      [15:0]           right_byte_en,
  output logic      [15:0]           check_en,
  output logic                       half_left
);
  import msarc_pkg::*;

  msarc_cpu_t   cpu_s1_r;
  msarc_cpu_t   cpu_s2_r;
  msarc_sense_t sns_s1_r;
  msarc_sense_t sns_s2_r;
  logic         clkp_d_r;
  logic         start;
  msarc_state_t state_r;
  logic [4:0]   tmr_r;
  logic [5:0]   cyc_r;
  logic [5:0]   cyc_nxt;
  logic         hit;
  logic [4:0]   row_r;
  logic         req_r;
  logic         tmo_r;
  logic         rrclr_tim;
  logic         req_clr;
  logic         sample;
  logic         grant;
  logic         timing;
  logic [0:4]   hi_hold_r;
  logic         ecc_fit_r;
  logic         ecc_err_r;
  logic         oor_r;
  logic [17:0]  hold_r;
  logic [8:0]   fix_left;
  logic [8:0]   fix_right;
  logic         wr_en;
  logic         mapped;
  logic [15:0]  col_dec;

  function automatic logic [15:0] msarc_onehot(input logic [3:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    v[sel] = 1'b1;
    return v;
  endfunction

  // returns {uncorrectable, byte}; single bit errors in data or check bits are fixed
  function automatic logic [8:0] msarc_correct(input logic [7:0] d, input logic [4:0] c);
    logic [12:1] cw;
    logic [3:0]  syn;
    logic        ov;
    logic        bad;
    cw  = {d[7:4], c[3], d[3:1], c[2], d[0], c[1], c[0]};
    syn = 4'h0;
    for (int p = 1; p <= 12; p++) begin
      if (cw[p]) begin
        syn = syn ^ p[3:0];
      end
    end
    ov  = ^{cw, c[4]};
    bad = (!ov && syn != 4'h0) || (ov && syn > 4'hC);
    if (ov && syn != 4'h0 && syn <= 4'hC) begin
      cw[syn] = ~cw[syn];
    end
    return {bad, cw[12], cw[11], cw[10], cw[9], cw[7], cw[6], cw[5], cw[3]};
  endfunction

  // pins cross in from the processor clock; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_s1_r <= '0;
      cpu_s2_r <= '0;
      sns_s1_r <= '0;
      sns_s2_r <= '0;
      clkp_d_r <= 1'b0;
    end else begin
      cpu_s1_r <= cpu_in;
      cpu_s2_r <= cpu_s1_r;
      sns_s1_r <= sense_in;
      sns_s2_r <= sns_s1_r;
      clkp_d_r <= cpu_s2_r.clk_pulse;
    end
  end

  // one cycle of 50 ns on the leading edge
  assign start = cpu_s2_r.clk_pulse & ~clkp_d_r;

  assign sample    = (state_r == ST_WAIT) && (tmr_r == 5'(SAMPLE_CYC));
  assign grant     = sample && !cpu_s2_r.access_en && req_r;
  assign timing    = (state_r == ST_ACCESS) || (state_r == ST_REFRESH);
  assign rrclr_tim = (state_r != ST_IDLE) && (tmr_r == 5'(RRCLR_CYC));
  assign req_clr   = rrclr_tim && (state_r == ST_REFRESH);

  // major cycle sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      tmr_r   <= 5'h00;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_WAIT;
            tmr_r   <= 5'(START_CYC);
          end
        end
        ST_WAIT: begin
          tmr_r <= tmr_r + 5'h01;
          if (sample) begin
            if (cpu_s2_r.access_en) begin
              state_r <= ST_ACCESS;
            end else if (req_r) begin
              state_r <= ST_REFRESH;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACCESS, ST_REFRESH: begin
          tmr_r <= tmr_r + 5'h01;
          // refresh holds storage for exactly one major cycle
          if (tmr_r == 5'(MAJOR_CYC - 1)) begin
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign cyc_nxt = cyc_r + 6'h01;
  assign hit     = start && (cyc_nxt == REFRESH_COUNT);

  // cycle counter; after a request it counts ignored cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_r <= 6'h00;
    end else if (grant) begin
      cyc_r <= 6'h00;
    end else if (hit) begin
      cyc_r <= 6'h00;
    end else if (start) begin
      cyc_r <= cyc_nxt;
    end
  end

  // row counter has no clear path besides power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_r <= 5'h00;
    end else if (hit) begin
      row_r <= row_r + 5'h01;
    end
  end

  // set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_r <= 1'b0;
    end else if (hit) begin
      req_r <= 1'b1;
    end else if (req_clr) begin
      req_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_r <= 1'b0;
    end else if (req_r && cyc_r == TIMEOUT_COUNT && rrclr_tim) begin
      tmo_r <= 1'b1;
    end else if (grant) begin
      tmo_r <= 1'b0;
    end
  end

  // upper bits loaded in ST_WAIT, frozen across the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_hold_r <= '0;
    end else if (state_r == ST_WAIT) begin
      hi_hold_r <= cpu_s2_r.addr[0:4];
    end
  end

  // only the low four decodes are reachable from two address bits
  assign col_dec = msarc_onehot({2'b00, hi_hold_r[3], hi_hold_r[4]});

  // address fan-out and selects, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elem_row  <= 5'h00;
      elem_col  <= 5'h00;
      col_sel   <= 4'h0;
      mod_sel   <= 16'h0000;
      half_left <= 1'b0;
      oor_r     <= 1'b0;
    end else begin
      unique case (state_r)
        ST_ACCESS: begin
          elem_row  <= cpu_s2_r.addr[10:14];
          elem_col  <= cpu_s2_r.addr[5:9];
          col_sel   <= col_dec[3:0];
          mod_sel   <= msarc_onehot(hi_hold_r[0:3]);
          half_left <= hi_hold_r[0];
          oor_r     <= |cpu_s2_r.ext;
        end
        ST_REFRESH: begin
          elem_row  <= row_r;
          elem_col  <= 5'h00;
          col_sel   <= 4'hF;
          mod_sel   <= 16'hFFFF;
          half_left <= 1'b0;
          oor_r     <= 1'b0;
        end
        default: begin
          elem_row  <= 5'h00;
          elem_col  <= 5'h00;
          col_sel   <= 4'h0;
          mod_sel   <= 16'h0000;
          half_left <= 1'b0;
          oor_r     <= oor_r;
        end
      endcase
    end
  end

  // selects are only non-zero while timing runs, so they already carry it
  assign board_addr_en = mod_sel;
  assign left_byte_en  = mod_sel;
  assign right_byte_en = mod_sel;
  assign check_en      = mod_sel & {16{ecc_fit_r}};

  for (genvar m = 0; m < 16; m++) begin : g_mod
    for (genvar c = 0; c < 4; c++) begin : g_col
      assign chip_en[m*4+c] = col_sel[c] & mod_sel[m];
    end
  end

  assign fix_left  = msarc_correct(sns_s2_r.left[7:0], sns_s2_r.chk_left);
  assign fix_right = msarc_correct(sns_s2_r.right[7:0], sns_s2_r.chk_right);

  // read data capture; check bits never leave the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_r    <= 18'h00000;
      ecc_err_r <= 1'b0;
    end else if (state_r == ST_ACCESS && tmr_r == 5'(STROBE_CYC)) begin
      if (ecc_fit_r) begin
        hold_r    <= {~^fix_left[7:0], fix_left[7:0], ~^fix_right[7:0], fix_right[7:0]};
        ecc_err_r <= fix_left[8] | fix_right[8];
      end else begin
        hold_r    <= {sns_s2_r.left, sns_s2_r.right};
        ecc_err_r <= 1'b0;
      end
    end
  end

  assign read_data       = hold_r;
  assign refresh_req     = req_r;
  assign refresh_timeout = tmo_r;
  assign out_of_range    = oor_r;
  assign ecc_error       = ecc_err_r;

  // apb: zero wait states, read data registered in the setup phase
  assign pready  = 1'b1;
  assign mapped  = (paddr == CTRL_OFF) || (paddr == STATUS_OFF) || (paddr == DATA_OFF);
  assign pslverr = psel & penable & ~mapped;
  assign wr_en   = psel & penable & pwrite & (paddr == CTRL_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_fit_r <= CTRL_RST;
    end else if (wr_en) begin
      ecc_fit_r <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h00000000;
      if (paddr == CTRL_OFF) begin
        prdata[0] <= ecc_fit_r;
      end else if (paddr == STATUS_OFF) begin
        prdata[ST_REQ_BIT]               <= req_r;
        prdata[ST_GNT_BIT]               <= (state_r == ST_REFRESH);
        prdata[ST_TMO_BIT]               <= tmo_r;
        prdata[ST_ECC_BIT]               <= ecc_err_r;
        prdata[ST_OOR_BIT]               <= oor_r;
        prdata[ST_ROW_LSB+4:ST_ROW_LSB]  <= row_r;
        prdata[ST_CYC_LSB+5:ST_CYC_LSB]  <= cyc_r;
      end else if (paddr == DATA_OFF) begin
        prdata[17:0] <= hold_r;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence grant_s;
    (state_r == ST_WAIT) && (tmr_r == 5'(SAMPLE_CYC)) && !cpu_s2_r.access_en && req_r;
  endsequence

  sequence refresh_cycle_s;
    (state_r == ST_REFRESH) [*8];
  endsequence

  start_one_cycle_a: assert property (start |=> !start)
    else $error("start pulse wider than one cycle");
  sample_access_a: assert property (sample && cpu_s2_r.access_en |=> state_r == ST_ACCESS)
    else $error("access enable not honoured at sample time");
  grant_refresh_a: assert property (grant_s |=> state_r == ST_REFRESH && cyc_r == 6'h00)
    else $error("blocked enable did not grant refresh");
  refresh_length_a: assert property (grant_s ##1 refresh_cycle_s |-> ##[1:12] state_r == ST_IDLE)
    else $error("refresh cycle length wrong");
  count_request_a: assert property (hit |=> req_r && cyc_r == 6'h00)
    else $error("count 52 did not raise request");
  row_advance_a: assert property (hit |=> row_r == $past(row_r) + 5'h01)
    else $error("refresh row did not advance");
  row_steady_a: assert property (!hit |=> $stable(row_r))
    else $error("refresh row changed without count");
  refresh_drive_a: assert property (state_r == ST_REFRESH |=> col_sel == 4'hF && mod_sel == 16'hFFFF)
    else $error("refresh did not select everything");
  refresh_addr_a: assert property (state_r == ST_REFRESH |=> elem_row == $past(row_r) && elem_col == 5'h00)
    else $error("refresh address wrong");
  module_onehot_a: assert property (state_r == ST_ACCESS |=> $onehot(mod_sel) && $onehot(col_sel))
    else $error("access select not one-hot");
  idle_gate_a: assert property (!timing |=> elem_row == 5'h00 && mod_sel == 16'h0000)
    else $error("address passed outside timing");
  request_clear_a: assert property (req_clr && !hit |=> !req_r)
    else $error("granted refresh did not clear request");
  timeout_set_a: assert property (req_r && cyc_r == TIMEOUT_COUNT && rrclr_tim |=> tmo_r)
    else $error("time-out not raised");
  timeout_hold_a: assert property (tmo_r && !grant |=> tmo_r)
    else $error("time-out dropped before grant");
endmodule // msarc_top
`default_nettype wire

// ===== test/msarc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// processor side: one storage cycle per call, 23 clocks long
module msarc_cpu_model (
  // clock
  input  wire logic                  pclk,
  // storage handshake
  input  wire logic                  refresh_req,
  output var  msarc_pkg::msarc_cpu_t cpu_out
);
  import msarc_pkg::*;
  initial cpu_out = '0;
  task automatic run(input logic [0:15] a, input logic [0:3] x, input logic blk, input logic hon);
    logic en;
    en = !(blk || (hon && refresh_req));
    cpu_out.addr      <= a; // storage registers only addr[0:4]; the low bits are read live
    cpu_out.ext       <= x;
    cpu_out.clk_pulse <= 1'b1; // clock leads access enable
    repeat (2) @(posedge pclk);
    cpu_out.clk_pulse <= 1'b0;
    cpu_out.access_en <= en; // settled well before storage samples it
    repeat (20) @(posedge pclk);
    cpu_out.access_en <= 1'b0;
    repeat (1) @(posedge pclk);
    cpu_out.addr <= ~a; // released bus shows no stale value
    cpu_out.ext  <= ~x;
  endtask
endmodule // msarc_cpu_model
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msarc_pkg::*;
  typedef struct {
    logic [0:15] a; logic [3:0] x; logic ecc; logic [8:0] l, r; logic [4:0] k;
    logic [17:0] rd; logic oor, err;
  } msarc_row_t;
  logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0, prdata, q;
  logic         pready, pslverr, rq, rto, oor, eerr, hl, e;
  logic [17:0]  rd;
  logic [4:0]   erow, ecol;
  logic [3:0]   cs;
  logic [15:0]  ms, bae, lbe, rbe, cke;
  logic [63:0]  ce;
  msarc_cpu_t   cpu;
  msarc_sense_t sense = '0;
  int           n_fail = 0, n_tests = 0, i;
  msarc_row_t   rows [6] = '{
    '{16'h0000, 4'h0, 1'b0, 9'h1A5, 9'h03C, 5'h00, 18'h34A3C, 1'b0, 1'b0},
    '{16'hFFFF, 4'h0, 1'b0, 9'h000, 9'h1FF, 5'h00, 18'h001FF, 1'b0, 1'b0},
    '{16'h8421, 4'h1, 1'b0, 9'h0FF, 9'h100, 5'h00, 18'h1FF00, 1'b1, 1'b0},
    '{16'h5A5A, 4'h8, 1'b0, 9'h055, 9'h0AA, 5'h00, 18'h0AAAA, 1'b1, 1'b0},
    '{16'hC369, 4'h0, 1'b1, 9'h000, 9'h000, 5'h03, 18'h00000, 1'b0, 1'b1},
    '{16'h3C96, 4'h0, 1'b1, 9'h000, 9'h000, 5'h01, 18'h20100, 1'b0, 1'b0}};

  always #25 pclk = ~pclk;

  msarc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_in(cpu),
    .refresh_req(rq), .refresh_timeout(rto), .out_of_range(oor), .ecc_error(eerr), .read_data(rd),
    .sense_in(sense), .elem_row(erow), .elem_col(ecol), .col_sel(cs), .mod_sel(ms), .board_addr_en(bae),
    .chip_en(ce), .left_byte_en(lbe), .right_byte_en(rbe), .check_en(cke), .half_left(hl));
  msarc_cpu_model i_cpu (.pclk(pclk), .refresh_req(rq), .cpu_out(cpu));

  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask

  task automatic conclude;
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // start a storage cycle, return in the middle of its access phase
  task automatic cyc(input logic [0:15] a, input logic [3:0] x, input logic blk, input logic hon);
    fork
      i_cpu.run(a, x, blk, hon);
    join_none
    repeat (13) @(posedge pclk);
    #1;
  endtask

  task automatic fin;
    repeat (11) @(posedge pclk);
    #1;
  endtask

  task automatic mid(input logic [0:15] a, input logic ecc);
    logic [3:0]  m;
    logic [1:0]  c;
    logic [15:0] ex;
    m  = a[0:3];
    c  = a[3:4];
    ex = 16'h0001 << m;
    chk("elem_row", a[10:14], erow);
    chk("elem_col", a[5:9], ecol);
    chk("col_sel", 4'h1 << c, cs);
    chk("mod_sel", ex, ms);
    chk("half_left", a[0], hl);
    chk("board_en", ex, bae);
    chk("chip_en", 64'h1 << {m, c}, ce);
    chk("byte_en", {ex, ex}, {lbe, rbe});
    chk("check_en", ecc ? ex : 16'h0000, cke);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    conclude;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CTRL_OFF, 32'h0);
    chk("ctrl_reset", CTRL_RST, q[0]);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("status_reset", 32'h0, q);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped_err", 1'b1, e);
    chk("unmapped_data", 32'h0, q);
    for (i = 0; i < 6; i++) begin
      apb(1'b1, CTRL_OFF, {31'h0, rows[i].ecc});
      sense <= {rows[i].l, rows[i].r, rows[i].k, 5'h00};
      cyc(rows[i].a, rows[i].x, 1'b0, 1'b0);
      mid(rows[i].a, rows[i].ecc);
      fin;
      chk("out_of_range", rows[i].oor, oor);
      chk("ecc_error", rows[i].err, eerr);
      if (!rows[i].err) chk("read_data", rows[i].rd, rd);
      chk("idle_mod_sel", 16'h0, ms);
    end
    apb(1'b0, DATA_OFF, 32'h0);
    chk("data_reg", rows[5].rd, q);
    apb(1'b1, CTRL_OFF, 32'h0);
    repeat (45) begin
      cyc(16'h1234, 4'h0, 1'b0, 1'b0);
      fin;
    end
    chk("req_at_51", 1'b0, rq);
    cyc(16'h1234, 4'h0, 1'b0, 1'b0);
    fin;
    chk("req_at_52", 1'b1, rq);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("row_advance", 5'h01, q[12:8]);
    for (i = 1; i <= 4; i++) begin
      cyc(16'h1234, 4'h0, 1'b0, 1'b0);
      fin;
      chk("timeout", i >= 3, rto);
    end
    cyc(16'hFFFF, 4'h0, 1'b0, 1'b1);
    chk("rf_mod_sel", 16'hFFFF, ms);
    chk("rf_col_sel", 4'hF, cs);
    chk("rf_row", 5'h01, erow);
    chk("rf_col", 5'h00, ecol);
    fin;
    chk("req_clear", 1'b0, rq);
    chk("timeout_clear", 1'b0, rto);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("count_clear", 6'h00, q[21:16]);
    chk("row_kept", 5'h01, q[12:8]);
    cyc(16'h0000, 4'h0, 1'b0, 1'b1);
    mid(16'h0000, 1'b0);
    fin;
    cyc(16'h5555, 4'h0, 1'b1, 1'b0);
    chk("null_mod_sel", 16'h0, ms);
    chk("null_row", 5'h00, erow);
    fin;
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk("rst_req", 1'b0, rq);
    chk("rst_data", 18'h0, rd);
    chk("rst_ready", 1'b1, pready);
    presetn <= 1'b1;
    apb(1'b0, STATUS_OFF, 32'h0);
    chk("rst_status", 32'h0, q);
    conclude;
  end
endmodule // tb
`default_nettype wire
